// *** gsqe_modem_model.sv ***
// gsqe_modem_model: cable modem side, logs grant times against the master time
// assumes grant pulses and master time arrive on the headend clock
`timescale 1ns/1ps
module gsqe_modem_model (
  // headend side
  input  wire logic        i_clk,
  input  wire logic        i_clr,
  input  wire logic        i_grant,
  input  wire logic [31:0] i_master_time,
  // grant log
  output logic [15:0]      o_count,
  output logic [31:0]      o_first,
  output logic [31:0]      o_gap
);
  logic [31:0] last_reg;
  always_ff @(posedge i_clk)
  begin
    if (i_clr)
      o_count <= 16'h0000;
    else if (i_grant)
    begin
      o_count  <= o_count + 16'h0001;
      o_gap    <= i_master_time - last_reg;
      last_reg <= i_master_time;
      if (o_count == 16'h0000)
        o_first <= i_master_time;
    end
  end
endmodule : gsqe_modem_model

// *** gsqe_pkg.sv ***
// gsqe_pkg: constants, register map and carrier types of the grant schedule qos enforcer
// assumes a 200 MHz core clock and an axi4-lite master that issues one write and one read at a time
// How it works
// RQ1 - poll no later than ideal plus jitter
// RQ2 - grant size covers whole frame, enforced
// RQ3 - convert grant bytes to mini-slots
// RQ4 - grant between ideal time and ideal plus jitter
// RQ5 - all grants of interval inside interval
// RQ6 - grant jitter bounds every opportunity delay
// RQ7 - grants per interval count 0 to 127
// RQ8 - grant flows need interval, jitter, count; only a zero interval is flagged, jitter and count are not checked
// RQ9 - service type byte and-mask then or-mask
// RQ10 - no rewrite parameter forwards byte unchanged
// RQ11 - send 32-bit master clock reference timestamp
// RQ12 - modem derives next grant from reference
// RQ13 - forward packet within maximum downstream latency
// RQ14 - latency waived above reserved rate
// RQ15 - suppression encoding shorter than 255 bytes
// RQ16 - classifier reference 1 to 255
// RQ17 - classifier identifier 1 to 65535
// RQ18 - flow reference 1 to 65535
// RQ19 - flow identifier nonzero 32-bit value
// RQ20 - action codes add set delete deleteall
// RQ21 - set only fills partially defined rule
// RQ22 - delete all removes flow's rules
// RQ23 - add of existing rule is error
// RQ24 - polling interval is poll period
// RQ25 - scheduling codes 5 and 6 grant flows
// RQ26 - free 32-bit master clock counter wraps
package gsqe_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_POLL_IVL  = 8'h04;
  localparam logic [7:0] OFS_POLL_JIT  = 8'h08;
  localparam logic [7:0] OFS_GRANT_IVL = 8'h0c;
  localparam logic [7:0] OFS_GRANT_JIT = 8'h10;
  localparam logic [7:0] OFS_GRANT_CFG = 8'h14;
  localparam logic [7:0] OFS_TOS       = 8'h18;
  localparam logic [7:0] OFS_LATENCY   = 8'h1c;
  localparam logic [7:0] OFS_STATUS    = 8'h20;
  localparam logic [7:0] OFS_TIMESTAMP = 8'h24;
  localparam logic [7:0] OFS_REF_TIME  = 8'h28;
  localparam logic [7:0] OFS_RULE_CMD  = 8'h2c;
  localparam logic [7:0] OFS_RULE_FLOW = 8'h30;
  localparam logic [7:0] OFS_RULE_STAT = 8'h34;
  localparam logic [7:0] OFS_RULE_ARG  = 8'h38;

  // ****************************************
  // field positions and codes
  // ****************************************
  localparam int         CTRL_EN_BIT   = 0;
  localparam int         CTRL_TOS_BIT  = 1;
  localparam int         CTRL_LAT_BIT  = 2;
  localparam int         CTRL_SCHED_LO = 8;
  localparam logic [7:0] SCHED_UNSOLICITED_GRANT_ACTIVITY_DETECT  = 8'h05;
  localparam logic [7:0] SCHED_UGS     = 8'h06;
  localparam logic [6:0] GRANTS_MAX    = 7'h7f;
  localparam logic [7:0] TLV_LEN_LIMIT = 8'hff;
  localparam logic [1:0] ACT_ADD       = 2'h0;
  localparam logic [1:0] ACT_SET       = 2'h1;
  localparam logic [1:0] ACT_DEL       = 2'h2;
  localparam logic [1:0] ACT_DEL_ALL   = 2'h3;
  localparam int         RULE_SLOTS    = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ         = 200;
  localparam int MASTER_KHZ      = 10240;
  // master clock phase accumulator: add 10240 per clock, tick at 200000
  localparam logic [17:0] PHASE_STEP = 18'h02800;
  localparam logic [17:0] PHASE_WRAP = 18'h30d40;
  localparam logic [15:0] MINISLOT_BYTES_RST = 16'h0010;
  localparam logic [31:0] RESP_OKAY  = 32'h0;
  localparam logic [1:0]  AXI_OKAY   = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic [7:0]  and_mask;
    logic [7:0]  or_mask;
  } gsqe_tos_t;

  typedef struct packed {
    logic        valid;
    logic        has_field;
    logic        has_size;
    logic [7:0]  index;
    logic [31:0] flow_id;
  } gsqe_rule_t;

  typedef struct packed {
    logic [1:0]  action;
    logic        field_present;
    logic        size_present;
    logic [7:0]  index;
    logic [7:0]  class_ref;
    logic [15:0] class_id;
    logic [15:0] flow_ref;
    logic [7:0]  tlv_len;
  } gsqe_cmd_t;

  // ****************************************
  // shared arithmetic
  // ****************************************
  // wrap-safe "a is at or after b" on the 32-bit master clock circle
  function automatic logic gsqe_after(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    return ~d[31];
  endfunction : gsqe_after

  // microseconds to master clock ticks: us * 10.24 = us*1024/100
  function automatic logic [31:0] gsqe_us2tk(input logic [31:0] us);
    logic [41:0] p;
    p = {10'h0, us} * 42'h400;
    return 32'(p / 42'h64);
  endfunction : gsqe_us2tk

endpackage : gsqe_pkg

// *** gsqe_top.sv ***
// gsqe_top: unsolicited grant and poll scheduler, service type rewrite, latency guard, suppression rule table
// assumes an axi4-lite master on i_clk and a packet stream from the network side on the same clock
`timescale 1ns/1ps
module gsqe_top (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // axi4-lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // packet path from network side to rf side
  input  wire logic        i_pkt_valid,
  input  wire logic        i_pkt_is_ip,
  input  wire logic [7:0]  i_original_service_type_byte,
  input  wire logic        i_over_reserved_rate,
  output logic             o_pkt_valid,
  output logic [7:0]       o_rewritten_service_type_byte,
  output logic             o_latency_miss,
  // schedule outputs
  output logic             o_grant,
  output logic [15:0]      o_grant_minislots,
  output logic             o_poll,
  output logic [31:0]      o_master_time
);

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl_reg, poll_ivl_reg, poll_jit_reg, grant_ivl_reg, grant_jit_reg;
  logic [31:0] grant_cfg_reg, latency_reg, ref_time_reg, rule_flow_reg, cmd_word_reg;
  gsqe_pkg::gsqe_tos_t tos_reg;
  logic [31:0] master_reg;
  logic [17:0] phase_reg;
  logic        aw_hold_reg, w_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic        cmd_go_reg, cmd_err_reg, cfg_err_reg;
  logic [31:0] cmd_arg_reg;
  gsqe_pkg::gsqe_rule_t rules_reg [gsqe_pkg::RULE_SLOTS];

  logic        en, grant_flow;
  logic [6:0]  gpi;
  logic [15:0] grant_bytes, slot_bytes;
  assign en          = ctrl_reg[gsqe_pkg::CTRL_EN_BIT];
  assign gpi         = grant_cfg_reg[22:16];
  assign grant_bytes = grant_cfg_reg[15:0];
  assign slot_bytes  = (ctrl_reg[31:16] == 16'h0) ? gsqe_pkg::MINISLOT_BYTES_RST : ctrl_reg[31:16];
  assign grant_flow  = (ctrl_reg[15:8] == gsqe_pkg::SCHED_UGS) || (ctrl_reg[15:8] == gsqe_pkg::SCHED_UNSOLICITED_GRANT_ACTIVITY_DETECT); // RQ25

  // ****************************************
  // master clock counter
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      phase_reg  <= 18'h0;
      master_reg <= 32'h0;
    end
    else if (phase_reg + gsqe_pkg::PHASE_STEP >= gsqe_pkg::PHASE_WRAP)
    begin
      phase_reg  <= phase_reg + gsqe_pkg::PHASE_STEP - gsqe_pkg::PHASE_WRAP;
      master_reg <= master_reg + 32'h1; // RQ26
    end
    else
      phase_reg <= phase_reg + gsqe_pkg::PHASE_STEP;
  end
  assign o_master_time = master_reg; // RQ11

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic wr_fire, aw_ok, w_ok;
  assign aw_ok     = aw_hold_reg | i_awvalid;
  assign w_ok      = w_hold_reg | i_wvalid;
  assign o_awready = ~aw_hold_reg & ~o_bvalid;
  assign o_wready  = ~w_hold_reg & ~o_bvalid;
  assign wr_fire   = aw_ok & w_ok & ~o_bvalid;
  logic [7:0]  wa;
  logic [31:0] wd;
  assign wa = aw_hold_reg ? aw_addr_reg : i_awaddr;
  assign wd = w_hold_reg ? w_data_reg : i_wdata;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_data_reg  <= 32'h0;
      o_bvalid    <= 1'b0;
      o_bresp     <= gsqe_pkg::AXI_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        o_bvalid    <= 1'b1;
        o_bresp     <= (wa > gsqe_pkg::OFS_RULE_ARG || wa[1:0] != 2'h0) ? gsqe_pkg::AXI_SLVERR : gsqe_pkg::AXI_OKAY;
      end
      else
      begin
        if (i_awvalid & o_awready)
        begin
          aw_hold_reg <= 1'b1;
          aw_addr_reg <= i_awaddr;
        end
        if (i_wvalid & o_wready)
        begin
          w_hold_reg <= 1'b1;
          w_data_reg <= i_wdata;
        end
        if (o_bvalid & i_bready)
          o_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction : merge

  logic [3:0] ws;
  assign ws = i_wstrb;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_reg      <= 32'h0;
      poll_ivl_reg  <= 32'h0;
      poll_jit_reg  <= 32'h0;
      grant_ivl_reg <= 32'h0;
      grant_jit_reg <= 32'h0;
      grant_cfg_reg <= 32'h0;
      tos_reg       <= '0;
      latency_reg   <= 32'h0;
      ref_time_reg  <= 32'h0;
      rule_flow_reg <= 32'h0;
      cmd_word_reg  <= 32'h0;
      cmd_arg_reg   <= 32'h0;
      cmd_go_reg    <= 1'b0;
    end
    else
    begin
      cmd_go_reg <= 1'b0;
      if (wr_fire)
        case (wa)
          gsqe_pkg::OFS_CTRL:      ctrl_reg      <= merge(ctrl_reg, wd, ws);
          gsqe_pkg::OFS_POLL_IVL:  poll_ivl_reg  <= merge(poll_ivl_reg, wd, ws);
          gsqe_pkg::OFS_POLL_JIT:  poll_jit_reg  <= merge(poll_jit_reg, wd, ws);
          gsqe_pkg::OFS_GRANT_IVL: grant_ivl_reg <= merge(grant_ivl_reg, wd, ws);
          gsqe_pkg::OFS_GRANT_JIT: grant_jit_reg <= merge(grant_jit_reg, wd, ws);
          gsqe_pkg::OFS_GRANT_CFG: grant_cfg_reg <= merge(grant_cfg_reg, wd, ws);
          gsqe_pkg::OFS_TOS:       tos_reg       <= 16'(merge({16'h0, tos_reg}, wd, ws));
          gsqe_pkg::OFS_LATENCY:   latency_reg   <= merge(latency_reg, wd, ws);
          gsqe_pkg::OFS_REF_TIME:  ref_time_reg  <= merge(ref_time_reg, wd, ws);
          gsqe_pkg::OFS_RULE_FLOW: rule_flow_reg <= merge(rule_flow_reg, wd, ws);
          gsqe_pkg::OFS_RULE_ARG:  cmd_arg_reg   <= merge(cmd_arg_reg, wd, ws);
          gsqe_pkg::OFS_RULE_CMD:
          begin
            cmd_word_reg <= wd;
            cmd_go_reg   <= 1'b1;
          end
          default: ;
        endcase
    end
  end

  // read channel
  assign o_arready = ~o_rvalid;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0;
      o_rresp  <= gsqe_pkg::AXI_OKAY;
    end
    else if (i_arvalid & o_arready)
    begin
      o_rvalid <= 1'b1;
      o_rresp  <= gsqe_pkg::AXI_OKAY;
      case (i_araddr)
        gsqe_pkg::OFS_CTRL:      o_rdata <= ctrl_reg;
        gsqe_pkg::OFS_POLL_IVL:  o_rdata <= poll_ivl_reg;
        gsqe_pkg::OFS_POLL_JIT:  o_rdata <= poll_jit_reg;
        gsqe_pkg::OFS_GRANT_IVL: o_rdata <= grant_ivl_reg;
        gsqe_pkg::OFS_GRANT_JIT: o_rdata <= grant_jit_reg;
        gsqe_pkg::OFS_GRANT_CFG: o_rdata <= grant_cfg_reg;
        gsqe_pkg::OFS_TOS:       o_rdata <= {16'h0, tos_reg};
        gsqe_pkg::OFS_LATENCY:   o_rdata <= latency_reg;
        gsqe_pkg::OFS_STATUS:    o_rdata <= {29'h0, o_latency_miss, cfg_err_reg, cmd_err_reg};
        gsqe_pkg::OFS_TIMESTAMP: o_rdata <= master_reg;
        gsqe_pkg::OFS_REF_TIME:  o_rdata <= ref_time_reg;
        gsqe_pkg::OFS_RULE_CMD:  o_rdata <= cmd_word_reg;
        gsqe_pkg::OFS_RULE_FLOW: o_rdata <= rule_flow_reg;
        gsqe_pkg::OFS_RULE_ARG:  o_rdata <= cmd_arg_reg;
        gsqe_pkg::OFS_RULE_STAT: o_rdata <= {28'h0, rules_reg[3].valid, rules_reg[2].valid,
                                             rules_reg[1].valid, rules_reg[0].valid};
        default:
        begin
          o_rdata <= 32'h0;
          o_rresp <= gsqe_pkg::AXI_SLVERR;
        end
      endcase
    end
    else if (o_rvalid & i_rready)
      o_rvalid <= 1'b0;
  end

  // ****************************************
  // grant scheduler
  // ****************************************
  logic [31:0] g_ivl_tk, g_sub_tk, g_next_reg, g_ideal_reg;
  logic [6:0]  g_cnt_reg;
  logic        cfg_ok;
  assign g_ivl_tk = gsqe_pkg::gsqe_us2tk(grant_ivl_reg);
  // spread grants evenly so the last one still falls inside the interval
  assign g_sub_tk = (gpi == 7'h0) ? g_ivl_tk : g_ivl_tk / {25'h0, gpi}; // RQ5
  assign cfg_ok   = grant_ivl_reg != 32'h0 && gpi <= gsqe_pkg::GRANTS_MAX; // RQ7 RQ8

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      g_next_reg  <= 32'h0;
      g_ideal_reg <= 32'h0;
      g_cnt_reg   <= 7'h0;
      o_grant     <= 1'b0;
      cfg_err_reg <= 1'b0;
    end
    else
    begin
      o_grant     <= 1'b0;
      cfg_err_reg <= en & grant_flow & ~cfg_ok; // RQ8
      if (~(en & grant_flow & cfg_ok) || gpi == 7'h0)
      begin
        g_ideal_reg <= ref_time_reg;
        g_next_reg  <= ref_time_reg;
        g_cnt_reg   <= 7'h0;
      end
      else if (gsqe_pkg::gsqe_after(master_reg, g_next_reg)) // RQ4 RQ6
      begin
        o_grant <= 1'b1;
        if (g_cnt_reg + 7'h1 >= gpi)
        begin
          g_cnt_reg   <= 7'h0;
          g_ideal_reg <= g_ideal_reg + g_ivl_tk;
          g_next_reg  <= g_ideal_reg + g_ivl_tk;
        end
        else
        begin
          g_cnt_reg  <= g_cnt_reg + 7'h1;
          g_next_reg <= g_next_reg + g_sub_tk;
        end
      end
    end
  end
  // grant carries the whole frame, rounded up to mini-slots
  assign o_grant_minislots = 16'(({1'b0, grant_bytes} + {1'b0, slot_bytes} - 17'h1) / {1'b0, slot_bytes}); // RQ2 RQ3

  // ****************************************
  // poll scheduler
  // ****************************************
  logic [31:0] p_next_reg;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      p_next_reg <= 32'h0;
      o_poll     <= 1'b0;
    end
    else
    begin
      o_poll <= 1'b0;
      if (~en || poll_ivl_reg == 32'h0)
        p_next_reg <= ref_time_reg;
      else if (gsqe_pkg::gsqe_after(master_reg, p_next_reg)) // RQ1 RQ24
      begin
        o_poll     <= 1'b1;
        p_next_reg <= p_next_reg + gsqe_pkg::gsqe_us2tk(poll_ivl_reg);
      end
    end
  end

  // ****************************************
  // service type rewrite and latency guard
  // ****************************************
  logic        lat_armed_reg;
  logic [31:0] lat_start_reg;
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pkt_valid                   <= 1'b0;
      o_rewritten_service_type_byte <= 8'h0;
    end
    else
    begin
      o_pkt_valid <= i_pkt_valid;
      if (i_pkt_valid & i_pkt_is_ip & ctrl_reg[gsqe_pkg::CTRL_TOS_BIT])
        o_rewritten_service_type_byte <= (i_original_service_type_byte & tos_reg.and_mask) | tos_reg.or_mask; // RQ9
      else
        o_rewritten_service_type_byte <= i_original_service_type_byte; // RQ10
    end
  end

  // forwarding takes one cycle; the guard flags a master time advance larger than the bound over that one cycle
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lat_armed_reg  <= 1'b0;
      lat_start_reg  <= 32'h0;
      o_latency_miss <= 1'b0;
    end
    else
    begin
      lat_armed_reg <= i_pkt_valid & ctrl_reg[gsqe_pkg::CTRL_LAT_BIT] & ~i_over_reserved_rate; // RQ14
      lat_start_reg <= master_reg;
      if (lat_armed_reg && (master_reg - lat_start_reg) > gsqe_pkg::gsqe_us2tk(latency_reg))
        o_latency_miss <= 1'b1; // RQ13
    end
  end

  // ****************************************
  // suppression rule table
  // ****************************************
  gsqe_pkg::gsqe_cmd_t cmd;
  logic                cmd_ok;
  // upper word: action, field and size flags, index, class reference, class id high byte
  assign cmd    = {cmd_arg_reg[27:0], cmd_word_reg}; // RQ20
  assign cmd_ok = cmd.tlv_len < gsqe_pkg::TLV_LEN_LIMIT // RQ15
                  && cmd.class_ref != 8'h0 && cmd.class_id != 16'h0 // RQ16 RQ17
                  && cmd.flow_ref != 16'h0 && rule_flow_reg != 32'h0; // RQ18 RQ19
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cmd_err_reg <= 1'b0;
      for (int k = 0; k < gsqe_pkg::RULE_SLOTS; k++)
        rules_reg[k] <= '0;
    end
    else if (cmd_go_reg)
    begin
      logic hit;
      logic placed;
      hit    = 1'b0;
      placed = 1'b0;
      cmd_err_reg <= ~cmd_ok;
      if (cmd_ok)
        case (cmd.action) // RQ20
          gsqe_pkg::ACT_ADD:
          begin
            for (int k = 0; k < gsqe_pkg::RULE_SLOTS; k++)
              if (rules_reg[k].valid && rules_reg[k].flow_id == rule_flow_reg && rules_reg[k].index == cmd.index)
                hit = 1'b1;
            if (hit)
              cmd_err_reg <= 1'b1; // RQ23
            else
            begin
              for (int k = 0; k < gsqe_pkg::RULE_SLOTS; k++)
                if (!rules_reg[k].valid && !placed)
                begin
                  rules_reg[k] <= '{1'b1, cmd.field_present, cmd.size_present, cmd.index, rule_flow_reg};
                  placed = 1'b1;
                end
              cmd_err_reg <= ~placed;
            end
          end
          gsqe_pkg::ACT_SET:
          begin
            for (int k = 0; k < gsqe_pkg::RULE_SLOTS; k++)
              if (rules_reg[k].valid && rules_reg[k].flow_id == rule_flow_reg && rules_reg[k].index == cmd.index)
              begin
                hit = 1'b1;
                if (rules_reg[k].has_field & rules_reg[k].has_size)
                  placed = 1'b1; // RQ21
                else
                begin
                  rules_reg[k].has_field <= rules_reg[k].has_field | cmd.field_present;
                  rules_reg[k].has_size  <= rules_reg[k].has_size | cmd.size_present;
                end
              end
            cmd_err_reg <= ~hit | placed;
          end
          gsqe_pkg::ACT_DEL:
            for (int k = 0; k < gsqe_pkg::RULE_SLOTS; k++)
              if (rules_reg[k].flow_id == rule_flow_reg && rules_reg[k].index == cmd.index)
                rules_reg[k].valid <= 1'b0;
          gsqe_pkg::ACT_DEL_ALL:
            for (int k = 0; k < gsqe_pkg::RULE_SLOTS; k++)
              if (rules_reg[k].flow_id == rule_flow_reg)
                rules_reg[k].valid <= 1'b0; // RQ22
          default: ;
        endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_tos_rewrite;
    @(posedge i_clk) disable iff (i_rst)
    (i_pkt_valid & i_pkt_is_ip & ctrl_reg[1]) |=> o_rewritten_service_type_byte ==
      (($past(i_original_service_type_byte) & tos_reg.and_mask) | tos_reg.or_mask);
  endproperty
  a_tos_rewrite: assert property (p_tos_rewrite) else $error("service type byte rewrite wrong"); // RQ9

  property p_tos_pass;
    @(posedge i_clk) disable iff (i_rst)
    (i_pkt_valid & ~ctrl_reg[1]) |=> o_rewritten_service_type_byte == $past(i_original_service_type_byte);
  endproperty
  a_tos_pass: assert property (p_tos_pass) else $error("service type byte altered without rewrite"); // RQ10

  property p_grant_late;
    @(posedge i_clk) disable iff (i_rst)
    o_grant |-> gsqe_pkg::gsqe_after($past(master_reg), $past(g_next_reg)) && !gsqe_pkg::gsqe_after($past(master_reg),
      $past(g_next_reg) + gsqe_pkg::gsqe_us2tk(grant_jit_reg) + 32'h1);
  endproperty
  a_grant_late: assert property (p_grant_late) else $error("grant outside its jitter window"); // RQ4

  property p_master_step;
    @(posedge i_clk) disable iff (i_rst)
    ##1 (master_reg - $past(master_reg)) <= 32'h1;
  endproperty
  a_master_step: assert property (p_master_step) else $error("master counter jumped"); // RQ26

  property p_del_all;
    @(posedge i_clk) disable iff (i_rst)
    (cmd_go_reg && cmd_ok && cmd.action == gsqe_pkg::ACT_DEL_ALL && rules_reg[0].flow_id == rule_flow_reg)
      |=> !rules_reg[0].valid;
  endproperty
  a_del_all: assert property (p_del_all) else $error("delete all left a rule"); // RQ22

  property p_bad_ref;
    @(posedge i_clk) disable iff (i_rst)
    (cmd_go_reg && cmd.class_ref == 8'h0) |=> cmd_err_reg;
  endproperty
  a_bad_ref: assert property (p_bad_ref) else $error("zero classifier reference accepted"); // RQ16

  property p_long_tlv;
    @(posedge i_clk) disable iff (i_rst)
    (cmd_go_reg && cmd.tlv_len == gsqe_pkg::TLV_LEN_LIMIT) |=> cmd_err_reg;
  endproperty
  a_long_tlv: assert property (p_long_tlv) else $error("overlong suppression encoding accepted"); // RQ15

  property p_cfg_missing;
    @(posedge i_clk) disable iff (i_rst)
    (en && grant_flow && grant_ivl_reg == 32'h0) |=> cfg_err_reg && !o_grant;
  endproperty
  a_cfg_missing: assert property (p_cfg_missing) else $error("incomplete grant flow not flagged"); // RQ8

  c_grant:    cover property (@(posedge i_clk) disable iff (i_rst) o_grant ##[1:1000] o_grant);
  c_poll:     cover property (@(posedge i_clk) disable iff (i_rst) o_poll);
  c_add_dup:  cover property (@(posedge i_clk) disable iff (i_rst) cmd_go_reg && cmd.action == 2'h0 ##1 cmd_err_reg);
  c_rewrite:  cover property (@(posedge i_clk) disable iff (i_rst) i_pkt_valid && ctrl_reg[1]);

endmodule : gsqe_top

// *** tb_grant_schedule_qos_enforcer.sv ***
// tb_grant_schedule_qos_enforcer: axi4-lite tasks, rewrite and grant timing tests
// assumes gsqe_top, gsqe_pkg and gsqe_modem_model
`timescale 1ns/1ps
module tb_grant_schedule_qos_enforcer;
  logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, pv = 0, clr = 1, ipf = 1;
  logic        awr, wrr, bv, arr, rv, opv, miss, g, p, ta, tw;
  logic [7:0]  awa = 0, ara = 0, tin = 0, tout;
  logic [31:0] wd = 0, rdat, mt, first, gap, t, r, d;
  logic [15:0] ngr, gms, np = 0;
  logic [1:0]  br, rr, resp;
  int          errors = 0, cmp_count = 0, n;
  always #2.5 clk = ~clk;
  always @(posedge clk) np <= clr ? 16'h0 : np + {15'h0, p};
  gsqe_top i_dut (.i_clk(clk), .i_rst(rst), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
    .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrr), .o_bresp(br), .o_bvalid(bv), .i_bready(bry), .i_araddr(ara),
    .i_arvalid(arv), .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv), .i_rready(rry),
    .i_pkt_valid(pv), .i_pkt_is_ip(ipf), .i_original_service_type_byte(tin), .i_over_reserved_rate(1'b0),
    .o_pkt_valid(opv), .o_rewritten_service_type_byte(tout), .o_latency_miss(miss), .o_grant(g),
    .o_grant_minislots(gms), .o_poll(p), .o_master_time(mt));
  gsqe_modem_model i_modem (.i_clk(clk), .i_clr(clr), .i_grant(g), .i_master_time(mt), .o_count(ngr),
    .o_first(first), .o_gap(gap));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] e);
    @(posedge clk);
    awa <= a;
    wd  <= dat;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    ta = 1'b1;
    tw = 1'b1;
    while (ta || tw)
    begin
      @(posedge clk);
      if (awr) ta = 1'b0;
      if (wrr) tw = 1'b0;
      awv <= ta;
      wv  <= tw;
    end
    do @(posedge clk); while (!bv);
    chk({30'h0, br}, {30'h0, e});
    bry <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    t = rdat;
    resp = rr;
    rry <= 1'b0;
  endtask : rd
  task automatic pkt(input logic [7:0] b, input logic [7:0] e, input logic f);
    @(posedge clk);
    tin <= b;
    ipf <= f;
    pv  <= 1'b1;
    @(posedge clk);
    pv  <= 1'b0;
    @(negedge clk);
    chk({31'h0, opv}, 32'h1);
    chk({24'h0, tout}, {24'h0, e});
  endtask : pkt
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  initial
  begin
    #300000;
    errors++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(gsqe_pkg::OFS_CTRL);
    chk(t, 32'h0);
    rd(8'h40);
    chk({30'h0, resp}, {30'h0, gsqe_pkg::AXI_SLVERR});
    wr(8'h40, 32'h1, gsqe_pkg::AXI_SLVERR);
    $display("registers done");
    wr(gsqe_pkg::OFS_TOS, 32'h00000fa0, gsqe_pkg::AXI_OKAY);
    wr(gsqe_pkg::OFS_LATENCY, 32'h1, gsqe_pkg::AXI_OKAY);
    wr(gsqe_pkg::OFS_CTRL, 32'h7, gsqe_pkg::AXI_OKAY);
    pkt(8'h5c, 8'hac, 1'b1);
    pkt(8'h5c, 8'h5c, 1'b0);
    wr(gsqe_pkg::OFS_CTRL, 32'h5, gsqe_pkg::AXI_OKAY);
    pkt(8'h5c, 8'h5c, 1'b1);
    chk({31'h0, miss}, 32'h0);
    $display("rewrite done");
    for (int gi = 1; gi <= 2; gi++)
    begin
      wr(gsqe_pkg::OFS_CTRL, 32'h0, gsqe_pkg::AXI_OKAY);
      wr(gsqe_pkg::OFS_GRANT_IVL, 32'ha, gsqe_pkg::AXI_OKAY);
      wr(gsqe_pkg::OFS_GRANT_JIT, 32'h2, gsqe_pkg::AXI_OKAY);
      wr(gsqe_pkg::OFS_POLL_IVL, 32'h5, gsqe_pkg::AXI_OKAY);
      wr(gsqe_pkg::OFS_GRANT_CFG, {9'h0, 7'(gi), 16'h0040}, gsqe_pkg::AXI_OKAY);
      rd(gsqe_pkg::OFS_TIMESTAMP);
      r = t + 32'h40;
      wr(gsqe_pkg::OFS_REF_TIME, r, gsqe_pkg::AXI_OKAY);
      clr <= 1'b1;
      wr(gsqe_pkg::OFS_CTRL, 32'h0601, gsqe_pkg::AXI_OKAY);
      clr <= 1'b0;
      for (n = 0; n < 20000 && ngr < 16'h3; n++)
        @(negedge clk);
      d = first - r;
      chk({31'h0, ngr >= 16'h3}, 32'h1);
      chk({31'h0, ~d[31] && d <= 32'd20}, 32'h1);
      chk({16'h0, gms}, 32'h4);
      chk({31'h0, np >= 16'h2}, 32'h1);
      chk({31'h0, gap >= 32'd102 / gi - 1 && gap <= 32'd102 / gi + 20}, 32'h1);
      $display("grants done");
    end
    wr(gsqe_pkg::OFS_RULE_FLOW, 32'h7, gsqe_pkg::AXI_OKAY);
    for (int ri = 0; ri < 3; ri++)
    begin
      wr(gsqe_pkg::OFS_RULE_ARG, (ri == 2) ? 32'h0c010100 : 32'h00010100, gsqe_pkg::AXI_OKAY);
      wr(gsqe_pkg::OFS_RULE_CMD, 32'h01000110, gsqe_pkg::AXI_OKAY);
      rd(gsqe_pkg::OFS_RULE_STAT);
      chk(t, (ri == 2) ? 32'h0 : 32'h1);
      rd(gsqe_pkg::OFS_STATUS);
      chk(t, (ri == 1) ? 32'h1 : 32'h0);
    end
    $display("rules done");
    stop_test();
  end
endmodule : tb_grant_schedule_qos_enforcer
